/* File: rif_regs.svh */
// register offsets, field positions, reset values for the radio irq status flags block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef RIF_REGS_SVH
`define RIF_REGS_SVH
`define RIF_STATUS_OFS      12'h01C
`define RIF_CTRL_OFS        12'h020
`define RIF_MASK_OFS        12'h024
`define RIF_EVT_OFS         12'h028
`define RIF_RX_READY_BIT    6
`define RIF_TX_DONE_BIT     5
`define RIF_RESERVED_BIT    7
`define RIF_CTRL_AUTO_ACK   0
`define RIF_EVT_RX_BIT      0
`define RIF_EVT_TX_BIT      1
`define RIF_STATUS_RESET    8'h00
`define RIF_MASK_RESET      2'h0
`define RIF_CTRL_RESET      1'h0
`endif

/* File: rif_pkg.sv */
// types shared by the radio irq status flags block
// assumes rif_regs.svh supplies offsets and reset values
package rif_pkg;
	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rif_apb_req_t;

	typedef struct packed
	{
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rif_apb_rsp_t;

	typedef struct packed
	{
		logic rx_ready;
		logic tx_done;
	} rif_flags_t;

	typedef struct packed
	{
		logic payload_stored;
		logic packet_sent;
		logic ack_received;
	} rif_events_t;
endpackage

/* File: rif_sync.sv */
// two-flop synchroniser for event pins from the radio core
// assumes asynchronous inputs; output is a level in the clk domain
`timescale 1ns/1ps
module rif_sync #(parameter int WIDTH = 3)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed
	{
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} rif_sync_state_t;

	rif_sync_state_t state;
	rif_sync_state_t next_state;

	always_comb
	begin
		next_state.stage1 = async_in;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign sync_out = state.stage2;
endmodule

/* File: rif_flag.sv */
// one sticky write-one-to-clear flag; a set in the same cycle as a clear wins
// assumes set and clear are single-cycle pulses on clk
`timescale 1ns/1ps
module rif_flag
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);
	typedef struct packed
	{
		logic flag;
	} rif_flag_state_t;

	rif_flag_state_t state;
	rif_flag_state_t next_state;

	always_comb
	begin
		next_state = state;
		if (clear)
			next_state.flag = 1'b0;
		if (set)
			next_state.flag = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign flag = state.flag;
endmodule

/* File: rif_status.sv */
// status flag bank of the radio transceiver: receive-data-ready and transmit-done,
// with control, interrupt mask and event registers, reached over apb
// assumes radio core event lines are asynchronous levels; one 250 MHz clock
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "rif_regs.svh"

// What this block does
// - Status bit 6 is set whenever a newly received payload is stored in the receive fifo.
// - Status bit 5 is set when a packet has gone out on air if auto acknowledge is off.
// - With auto acknowledge on, bit 5 is set only once the acknowledgement has arrived.
// - Writing one to status bit 5 clears it unless a new set arrives in the same cycle, and writing zero leaves it unchanged.
module rif_status
(
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire rif_pkg::rif_apb_req_t apb_req,
	output rif_pkg::rif_apb_rsp_t      apb_rsp,
	input  wire rif_pkg::rif_events_t  radio_events,
	output logic                       irq,
	output logic                       auto_ack_enable
);
	typedef enum logic [0:0]
	{
		RIF_IDLE   = 1'b0,
		RIF_ANSWER = 1'b1
	} rif_phase_t;

	typedef struct packed
	{
		rif_phase_t           phase;
		rif_pkg::rif_apb_rsp_t rsp;
		logic                 auto_ack;
		rif_pkg::rif_flags_t  mask;
		rif_pkg::rif_flags_t  evt;
		logic                 irq;
		rif_pkg::rif_events_t ev_prev;
	} rif_state_t;

	rif_state_t state;
	rif_state_t next_state;

	logic [2:0]          ev_sync;
	rif_pkg::rif_events_t ev_now;
	logic                set_rx;
	logic                set_tx;
	logic                clr_rx;
	logic                clr_tx;
	logic                rx_flag;
	logic                tx_flag;
	logic                bus_wr;
	logic                bus_rd;
	logic                evt_set_rx;
	logic                evt_set_tx;
	logic                evt_rd;
	logic [7:0]          status_word;

	rif_sync #(.WIDTH(3)) u_sync
	(
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (radio_events),
		.sync_out (ev_sync)
	);

	assign ev_now = rif_pkg::rif_events_t'(ev_sync);
	// writes land at the access edge, where pready is sampled high
	assign bus_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& state.phase == RIF_ANSWER;
	assign bus_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// rising edges of the synchronised radio events
	assign set_rx = ev_now.payload_stored && !state.ev_prev.payload_stored;
	// end of transmission counts only without auto acknowledge
	assign set_tx = state.auto_ack
		? (ev_now.ack_received && !state.ev_prev.ack_received)
		: (ev_now.packet_sent && !state.ev_prev.packet_sent);

	assign clr_rx = bus_wr && apb_req.paddr == `RIF_STATUS_OFS
		&& apb_req.pwdata[`RIF_RX_READY_BIT];
	assign clr_tx = bus_wr && apb_req.paddr == `RIF_STATUS_OFS
		&& apb_req.pwdata[`RIF_TX_DONE_BIT];

	rif_flag u_rx_flag
	(
		.clk     (clk),
		.reset_n (reset_n),
		.set     (set_rx),
		.clear   (clr_rx),
		.flag    (rx_flag)
	);

	rif_flag u_tx_flag
	(
		.clk     (clk),
		.reset_n (reset_n),
		.set     (set_tx),
		.clear   (clr_tx),
		.flag    (tx_flag)
	);

	assign evt_rd = bus_rd && apb_req.paddr == `RIF_EVT_OFS;
	assign evt_set_rx = set_rx;
	assign evt_set_tx = set_tx;

	always_comb
	begin
		status_word = 8'h00;
		status_word[`RIF_RESERVED_BIT] = 1'b0;
		status_word[`RIF_RX_READY_BIT] = rx_flag;
		status_word[`RIF_TX_DONE_BIT] = tx_flag;
	end

	always_comb
	begin
		next_state = state;
		next_state.ev_prev = ev_now;
		next_state.rsp.pready = 1'b0;
		next_state.rsp.pslverr = 1'b0;
		// read-to-clear event latch; a new event in the read cycle survives
		if (evt_rd && state.phase == RIF_IDLE)
			next_state.evt = '0;
		if (evt_set_rx)
			next_state.evt.rx_ready = 1'b1;
		if (evt_set_tx)
			next_state.evt.tx_done = 1'b1;
		unique case (state.phase)
			RIF_IDLE:
			begin
				if (apb_req.psel && !apb_req.penable)
				begin
					next_state.phase = RIF_ANSWER;
					next_state.rsp.pready = 1'b1;
					next_state.rsp.prdata = 32'h0000_0000;
					unique case (apb_req.paddr)
						`RIF_STATUS_OFS:
							next_state.rsp.prdata = {24'h00_0000, status_word};
						`RIF_CTRL_OFS:
						begin
							next_state.rsp.prdata = {31'h0000_0000, state.auto_ack};
						end
						`RIF_MASK_OFS:
						begin
							next_state.rsp.prdata = {30'h0000_0000, state.mask};
						end
						`RIF_EVT_OFS:
							next_state.rsp.prdata = {30'h0000_0000, state.evt};
						default:
							next_state.rsp.pslverr = 1'b1;
					endcase
				end
			end
			RIF_ANSWER:
			begin
				next_state.phase = RIF_IDLE;
				if (bus_wr && apb_req.paddr == `RIF_CTRL_OFS)
					next_state.auto_ack = apb_req.pwdata[`RIF_CTRL_AUTO_ACK];
				if (bus_wr && apb_req.paddr == `RIF_MASK_OFS)
					next_state.mask = apb_req.pwdata[1:0];
			end
		endcase
		next_state.irq = |(next_state.evt & next_state.mask);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= '0;
			state.auto_ack <= `RIF_CTRL_RESET;
			state.mask <= `RIF_MASK_RESET;
		end
		else
			state <= next_state;
	end

	assign apb_rsp = state.rsp;
	assign irq = state.irq;
	assign auto_ack_enable = state.auto_ack;
endmodule

/* File: rif_status_asserts.sv */
// concurrent checks on the status flag bank ports
// assumes bind to rif_status; the mask is shadowed from apb access-phase writes with pready high
`timescale 1ns/1ps
`include "rif_regs.svh"
module rif_status_asserts
(
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire rif_pkg::rif_apb_req_t apb_req,
	input wire rif_pkg::rif_apb_rsp_t apb_rsp,
	input wire rif_pkg::rif_events_t  radio_events,
	input wire logic                  irq,
	input wire logic                  auto_ack_enable
);
	logic [1:0] m;
	logic       mwr;
	logic       srd;
	assign mwr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
		&& apb_req.paddr == `RIF_MASK_OFS;
	assign srd = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `RIF_STATUS_OFS;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			m <= 2'h0;
		else if (mwr)
			m <= apb_req.pwdata[1:0];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	AST_RX: assert property ($rose(radio_events.payload_stored) && m[1] |-> ##[1:5] irq)
		else $error("rx event gave no irq");
	AST_TX: assert property (!auto_ack_enable && $rose(radio_events.packet_sent) && m[0]
		|-> ##[1:5] irq) else $error("sent event gave no irq");
	AST_ACK: assert property (auto_ack_enable && $rose(radio_events.ack_received) && m[0]
		|-> ##[1:5] irq) else $error("ack event gave no irq");
	AST_GATE: assert property (auto_ack_enable && m[0] && !irq && $rose(radio_events.packet_sent)
		|-> ##1 !irq [*5]) else $error("sent raised irq while ack pending");
	AST_NOMASK: assert property (m == 2'h0 && $past(m) == 2'h0 |-> !irq)
		else $error("irq with all sources masked");
	AST_RSV: assert property (srd |-> apb_rsp.prdata[31:7] == 25'h0)
		else $error("reserved status bits read nonzero");
endmodule
bind rif_status rif_status_asserts u_chk (.clk(clk), .reset_n(reset_n), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .radio_events(radio_events), .irq(irq), .auto_ack_enable(auto_ack_enable));

/* File: tb_top.sv */
// self-checking bench for the status flag bank
// assumes zero-wait apb answers and a two-flop event synchroniser
`timescale 1ns/1ps
`include "rif_regs.svh"
module tb_top;
	logic                  clk = 1'b0;
	logic                  reset_n = 1'b0;
	rif_pkg::rif_apb_req_t q = '0;
	rif_pkg::rif_apb_rsp_t s;
	logic [2:0]            ev = 3'h0;
	logic                  irq;
	logic                  aa;
	int                    n_errors = 0;
	int                    total_checks = 0;
	int                    cyc = 0;
	logic                  last_err = 1'b0;
	always #2 clk = ~clk;
	rif_status dut (.clk(clk), .reset_n(reset_n), .apb_req(q), .apb_rsp(s),
		.radio_events(ev), .irq(irq), .auto_ack_enable(aa));
	task print_verdict;
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] v, input logic [31:0] e);
		total_checks++;
		if (v !== e)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, v);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		q <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		q.penable <= 1'b1;
		do @(posedge clk); while (s.pready !== 1'b1);
		r = s.prdata;
		last_err = s.pslverr;
		q <= '0;
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk("prdata", r, e);
	endtask
	task pulse(input int i);
		ev[i] <= 1'b1;
		repeat (3) @(posedge clk);
		ev[i] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task ck_irq(input logic e);
		@(negedge clk);
		chk("irq", irq, e);
		@(posedge clk);
	endtask
	task t_reset;
		rd(`RIF_STATUS_OFS, 32'h0);
		chk("pslverr", last_err, 1'b0);
		rd(`RIF_CTRL_OFS, 32'h0);
		rd(`RIF_MASK_OFS, 32'h0);
		rd(12'h000, 32'h0);
		chk("pslverr", last_err, 1'b1);
	endtask
	task t_rx;
		pulse(2);
		ck_irq(1'b0);
		rd(`RIF_STATUS_OFS, 32'h40);
		wr(`RIF_STATUS_OFS, 32'h0);
		rd(`RIF_STATUS_OFS, 32'h40);
		wr(`RIF_STATUS_OFS, 32'h40);
		rd(`RIF_STATUS_OFS, 32'h0);
		wr(`RIF_MASK_OFS, 32'h2);
		ck_irq(1'b1);
		rd(`RIF_EVT_OFS, 32'h2);
		ck_irq(1'b0);
		pulse(2);
		ck_irq(1'b1);
		wr(`RIF_STATUS_OFS, 32'h40);
		rd(`RIF_EVT_OFS, 32'h2);
	endtask
	task t_tx;
		wr(`RIF_MASK_OFS, 32'h1);
		pulse(1);
		ck_irq(1'b1);
		rd(`RIF_STATUS_OFS, 32'h20);
		wr(`RIF_STATUS_OFS, 32'h40);
		rd(`RIF_STATUS_OFS, 32'h20);
		wr(`RIF_STATUS_OFS, 32'h20);
		rd(`RIF_STATUS_OFS, 32'h0);
		rd(`RIF_EVT_OFS, 32'h1);
	endtask
	task t_ack;
		wr(`RIF_CTRL_OFS, 32'h1);
		@(negedge clk);
		chk("auto_ack", aa, 1'b1);
		@(posedge clk);
		pulse(1);
		ck_irq(1'b0);
		rd(`RIF_STATUS_OFS, 32'h0);
		pulse(0);
		ck_irq(1'b1);
		rd(`RIF_STATUS_OFS, 32'h20);
		rd(`RIF_EVT_OFS, 32'h1);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_rx;
		t_tx;
		t_ack;
		print_verdict;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			print_verdict;
		end
	end
endmodule
